// ===== shared/thermal_fan_monitor_pkg.sv
package thermal_fan_monitor_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_REGS = 32;
  localparam int unsigned IDX_W = 5;

  // register offsets
  localparam logic [7:0] MAIN_CONFIGURATION_ADDR   = 8'h00;
  localparam logic [7:0] EXTENDED_TEMP_BITS_ADDR   = 8'h06;
  localparam logic [7:0] FAN1_TACH_COUNT_ADDR      = 8'h08;
  localparam logic [7:0] FAN2_TACH_COUNT_ADDR      = 8'h09;
  localparam logic [7:0] LOCAL_TEMP_READING_ADDR   = 8'h0a;
  localparam logic [7:0] REMOTE1_TEMP_READING_ADDR = 8'h0b;
  localparam logic [7:0] REMOTE2_TEMP_READING_ADDR = 8'h0c;
  localparam logic [7:0] LOCAL_TEMP_OFFSET_ADDR    = 8'h0d;
  localparam logic [7:0] REMOTE1_TEMP_OFFSET_ADDR  = 8'h0e;
  localparam logic [7:0] REMOTE2_TEMP_OFFSET_ADDR  = 8'h0f;
  localparam logic [7:0] FAN1_SLOW_LIMIT_ADDR      = 8'h10;
  localparam logic [7:0] FAN2_SLOW_LIMIT_ADDR      = 8'h11;
  localparam logic [7:0] LOCAL_UPPER_LIMIT_ADDR    = 8'h14;
  localparam logic [7:0] LOCAL_LOWER_LIMIT_ADDR    = 8'h15;
  localparam logic [7:0] LOCAL_OVERTEMP_LIMIT_ADDR = 8'h16;
  localparam logic [7:0] REMOTE1_UPPER_LIMIT_ADDR  = 8'h18;
  localparam logic [7:0] REMOTE1_LOWER_LIMIT_ADDR  = 8'h19;
  localparam logic [7:0] REMOTE1_OVERTEMP_ADDR     = 8'h1a;
  localparam logic [7:0] REMOTE2_UPPER_LIMIT_ADDR  = 8'h1c;
  localparam logic [7:0] REMOTE2_LOWER_LIMIT_ADDR  = 8'h1d;
  localparam logic [7:0] REMOTE2_OVERTEMP_ADDR     = 8'h1e;

  // main configuration fields
  localparam int unsigned CFG_MONITOR_BIT     = 0;
  localparam int unsigned CFG_ALERT_EN_BIT    = 1;
  localparam int unsigned CFG_SPEED_INPUT_BIT = 2;
  localparam int unsigned CFG_INVERT_BIT      = 3;
  localparam int unsigned CFG_FAULT_EN_BIT    = 4;
  localparam int unsigned CFG_MAP_LSB         = 5;
  localparam int unsigned CFG_AUTO_BIT        = 7;

  // fan source mapping codes
  localparam logic [1:0] MAP_SPLIT   = 2'h0;
  localparam logic [1:0] MAP_REMOTE1 = 2'h1;
  localparam logic [1:0] MAP_REMOTE2 = 2'h2;
  localparam logic [1:0] MAP_MAXIMUM = 2'h3;

  // extended bits layout
  localparam int unsigned EXT_REMOTE1_LSB = 0;
  localparam int unsigned EXT_REMOTE2_LSB = 3;
  localparam int unsigned EXT_LOCAL_LSB   = 6;

  // reset values, temperatures at 1 degC per lsb
  localparam logic [7:0] MAIN_CONFIGURATION_RST = 8'h90;
  localparam logic [7:0] ZERO_RST               = 8'h00;
  localparam logic [7:0] SLOW_LIMIT_RST         = 8'hff;
  localparam logic [7:0] LOCAL_UPPER_RST        = 8'h3c;
  localparam logic [7:0] LOCAL_OVERTEMP_RST     = 8'h46;
  localparam logic [7:0] REMOTE_UPPER_RST       = 8'h50;
  localparam logic [7:0] REMOTE_OVERTEMP_RST    = 8'h64;

  localparam logic [2:0] FAULT_STRIKES = 3'h5;

  typedef enum logic [1:0] {
    SRC_LOCAL,
    SRC_REMOTE1,
    SRC_REMOTE2,
    SRC_HOTTEST
  } source_e;

endpackage : thermal_fan_monitor_pkg

// ===== src/thermal_fan_monitor_regs.sv
`timescale 1ns/10ps
module thermal_fan_monitor_regs (
  input  wire logic        core_clk_i,        // system clock
  input  wire logic        srst_i,            // sync reset, active high
  input  wire logic        ce_i,              // clock enable
  input  wire logic [7:0]  reg_addr_i,        // register offset
  input  wire logic        reg_wr_i,          // write strobe
  input  wire logic [7:0]  reg_wdata_i,       // write data
  input  wire logic        reg_rd_i,          // read strobe
  output logic      [7:0]  reg_rdata_o,       // read data, one cycle after strobe
  output logic             reg_rvalid_o,      // read data valid pulse
  input  wire logic [1:0]  tach_valid_i,      // new tach count per fan
  input  wire logic [7:0]  fan1_tach_i,       // fan 1 measured count
  input  wire logic [7:0]  fan2_tach_i,       // fan 2 measured count
  input  wire logic        temp_valid_i,      // new temperature set
  input  wire logic [7:0]  local_temp_i,      // local reading, upper bits
  input  wire logic [7:0]  remote1_temp_i,    // remote 1 reading, upper bits
  input  wire logic [7:0]  remote2_temp_i,    // remote 2 reading, upper bits
  input  wire logic [7:0]  ext_bits_i,        // extended resolution bits
  input  wire logic        alert_req_i,       // interrupt request from status
  input  wire logic [1:0]  drive_raw_i,       // fan drive before polarity
  output logic             monitor_en_o,      // measurement running
  output logic             speed_input_select_o, // 1: analog speed inputs
  output logic             automatic_control_select_o, // 1: automatic
  output logic             rpm_targets_o,     // software mode rpm targets
  output logic [1:0]       fan1_source_o,     // fan 1 temperature source
  output logic [1:0]       fan2_source_o,     // fan 2 temperature source
  output logic [7:0]       fan1_ctrl_temp_o,  // fan 1 controlling temperature
  output logic [7:0]       fan2_ctrl_temp_o,  // fan 2 controlling temperature
  output logic [1:0]       drive_o,           // fan drive after polarity
  output logic [1:0]       fan_slow_o,        // latest count above limit
  output logic             int_o,             // interrupt pin level, low
  output logic             int_oe_o,          // interrupt pin enable
  output logic             fan_fault_o,       // fan-failure pin level, low
  output logic             fan_fault_oe_o     // fan-failure pin enable
);

  //////////////////////////////////////////////////////////////////////////////
  // address map helpers

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      thermal_fan_monitor_pkg::MAIN_CONFIGURATION_ADDR,
      thermal_fan_monitor_pkg::EXTENDED_TEMP_BITS_ADDR,
      thermal_fan_monitor_pkg::FAN1_TACH_COUNT_ADDR,
      thermal_fan_monitor_pkg::FAN2_TACH_COUNT_ADDR,
      thermal_fan_monitor_pkg::LOCAL_TEMP_READING_ADDR,
      thermal_fan_monitor_pkg::REMOTE1_TEMP_READING_ADDR,
      thermal_fan_monitor_pkg::REMOTE2_TEMP_READING_ADDR,
      thermal_fan_monitor_pkg::LOCAL_TEMP_OFFSET_ADDR,
      thermal_fan_monitor_pkg::REMOTE1_TEMP_OFFSET_ADDR,
      thermal_fan_monitor_pkg::REMOTE2_TEMP_OFFSET_ADDR,
      thermal_fan_monitor_pkg::FAN1_SLOW_LIMIT_ADDR,
      thermal_fan_monitor_pkg::FAN2_SLOW_LIMIT_ADDR,
      thermal_fan_monitor_pkg::LOCAL_UPPER_LIMIT_ADDR,
      thermal_fan_monitor_pkg::LOCAL_LOWER_LIMIT_ADDR,
      thermal_fan_monitor_pkg::LOCAL_OVERTEMP_LIMIT_ADDR,
      thermal_fan_monitor_pkg::REMOTE1_UPPER_LIMIT_ADDR,
      thermal_fan_monitor_pkg::REMOTE1_LOWER_LIMIT_ADDR,
      thermal_fan_monitor_pkg::REMOTE1_OVERTEMP_ADDR,
      thermal_fan_monitor_pkg::REMOTE2_UPPER_LIMIT_ADDR,
      thermal_fan_monitor_pkg::REMOTE2_LOWER_LIMIT_ADDR,
      thermal_fan_monitor_pkg::REMOTE2_OVERTEMP_ADDR: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // readings and resolution bits are fed by the engine only
  function automatic logic is_read_only(input logic [7:0] a);
    case (a)
      thermal_fan_monitor_pkg::EXTENDED_TEMP_BITS_ADDR,
      thermal_fan_monitor_pkg::LOCAL_TEMP_READING_ADDR,
      thermal_fan_monitor_pkg::REMOTE1_TEMP_READING_ADDR,
      thermal_fan_monitor_pkg::REMOTE2_TEMP_READING_ADDR: is_read_only = 1'b1;
      default: is_read_only = 1'b0;
    endcase
  endfunction : is_read_only

  function automatic logic [7:0] reset_value(input logic [7:0] a);
    case (a)
      thermal_fan_monitor_pkg::MAIN_CONFIGURATION_ADDR:
        reset_value = thermal_fan_monitor_pkg::MAIN_CONFIGURATION_RST;
      thermal_fan_monitor_pkg::FAN1_SLOW_LIMIT_ADDR,
      thermal_fan_monitor_pkg::FAN2_SLOW_LIMIT_ADDR:
        reset_value = thermal_fan_monitor_pkg::SLOW_LIMIT_RST;
      thermal_fan_monitor_pkg::LOCAL_UPPER_LIMIT_ADDR:
        reset_value = thermal_fan_monitor_pkg::LOCAL_UPPER_RST;
      thermal_fan_monitor_pkg::LOCAL_OVERTEMP_LIMIT_ADDR:
        reset_value = thermal_fan_monitor_pkg::LOCAL_OVERTEMP_RST;
      thermal_fan_monitor_pkg::REMOTE1_UPPER_LIMIT_ADDR,
      thermal_fan_monitor_pkg::REMOTE2_UPPER_LIMIT_ADDR:
        reset_value = thermal_fan_monitor_pkg::REMOTE_UPPER_RST;
      thermal_fan_monitor_pkg::REMOTE1_OVERTEMP_ADDR,
      thermal_fan_monitor_pkg::REMOTE2_OVERTEMP_ADDR:
        reset_value = thermal_fan_monitor_pkg::REMOTE_OVERTEMP_RST;
      // offsets, lower limits, readings all clear
      default: reset_value = thermal_fan_monitor_pkg::ZERO_RST;
    endcase
  endfunction : reset_value

  //////////////////////////////////////////////////////////////////////////////
  // storage

  logic [7:0] regs_q [thermal_fan_monitor_pkg::NUM_REGS];
  logic [7:0] hw_data [thermal_fan_monitor_pkg::NUM_REGS];
  logic       hw_we   [thermal_fan_monitor_pkg::NUM_REGS];
  logic [7:0] cfg;
  logic       meas_en;
  logic       host_wr;

  assign cfg     = regs_q[thermal_fan_monitor_pkg::MAIN_CONFIGURATION_ADDR[4:0]];
  assign meas_en = cfg[thermal_fan_monitor_pkg::CFG_MONITOR_BIT];
  assign host_wr = reg_wr_i && is_mapped(reg_addr_i) && !is_read_only(reg_addr_i);

  // engine updates, only while monitoring runs
  always_comb begin
    for (int k = 0; k < thermal_fan_monitor_pkg::NUM_REGS; k++) begin
      hw_we[k]   = 1'b0;
      hw_data[k] = 8'h00;
    end
    hw_we[thermal_fan_monitor_pkg::FAN1_TACH_COUNT_ADDR[4:0]]   = meas_en && tach_valid_i[0];
    hw_data[thermal_fan_monitor_pkg::FAN1_TACH_COUNT_ADDR[4:0]] = fan1_tach_i;
    hw_we[thermal_fan_monitor_pkg::FAN2_TACH_COUNT_ADDR[4:0]]   = meas_en && tach_valid_i[1];
    hw_data[thermal_fan_monitor_pkg::FAN2_TACH_COUNT_ADDR[4:0]] = fan2_tach_i;
    hw_we[thermal_fan_monitor_pkg::LOCAL_TEMP_READING_ADDR[4:0]]   = meas_en && temp_valid_i;
    hw_data[thermal_fan_monitor_pkg::LOCAL_TEMP_READING_ADDR[4:0]] = local_temp_i;
    hw_we[thermal_fan_monitor_pkg::REMOTE1_TEMP_READING_ADDR[4:0]]   = meas_en && temp_valid_i;
    hw_data[thermal_fan_monitor_pkg::REMOTE1_TEMP_READING_ADDR[4:0]] = remote1_temp_i;
    hw_we[thermal_fan_monitor_pkg::REMOTE2_TEMP_READING_ADDR[4:0]]   = meas_en && temp_valid_i;
    hw_data[thermal_fan_monitor_pkg::REMOTE2_TEMP_READING_ADDR[4:0]] = remote2_temp_i;
    hw_we[thermal_fan_monitor_pkg::EXTENDED_TEMP_BITS_ADDR[4:0]]   = meas_en && temp_valid_i;
    hw_data[thermal_fan_monitor_pkg::EXTENDED_TEMP_BITS_ADDR[4:0]] = ext_bits_i;
  end

  // a fresh measurement wins over a host write in the same cycle
  for (genvar g = 0; g < thermal_fan_monitor_pkg::NUM_REGS; g++) begin : g_reg
    always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
        regs_q[g] <= reset_value(8'(g));
      end else if (ce_i) begin
        if (hw_we[g]) begin
          regs_q[g] <= hw_data[g];
        end else if (host_wr && reg_addr_i == 8'(g)) begin
          regs_q[g] <= reg_wdata_i;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        if (is_mapped(reg_addr_i)) begin
          reg_rdata_o <= regs_q[reg_addr_i[4:0]];
        end else begin
          reg_rdata_o <= 8'h00;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration decode

  logic [1:0] map_sel;
  logic       auto_mode;

  assign map_sel   = cfg[thermal_fan_monitor_pkg::CFG_MAP_LSB +: 2];
  assign auto_mode = cfg[thermal_fan_monitor_pkg::CFG_AUTO_BIT];

  assign monitor_en_o               = meas_en;
  assign speed_input_select_o       = cfg[thermal_fan_monitor_pkg::CFG_SPEED_INPUT_BIT];
  assign automatic_control_select_o = auto_mode;
  // 01 and 10 in software mode keep duty targets
  assign rpm_targets_o = !auto_mode && map_sel == thermal_fan_monitor_pkg::MAP_MAXIMUM;

  // alert pin is open drain, driven low only when gated on
  assign int_o    = 1'b0;
  assign int_oe_o = alert_req_i && cfg[thermal_fan_monitor_pkg::CFG_ALERT_EN_BIT];

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      drive_o <= 2'h0;
    end else if (ce_i) begin
      drive_o <= drive_raw_i ^ {2{cfg[thermal_fan_monitor_pkg::CFG_INVERT_BIT]}};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // temperature source mapping

  logic [7:0] t_loc;
  logic [7:0] t_r1;
  logic [7:0] t_r2;
  logic [7:0] t_max;
  logic [7:0] t_hi;

  assign t_loc = regs_q[thermal_fan_monitor_pkg::LOCAL_TEMP_READING_ADDR[4:0]];
  assign t_r1  = regs_q[thermal_fan_monitor_pkg::REMOTE1_TEMP_READING_ADDR[4:0]];
  assign t_r2  = regs_q[thermal_fan_monitor_pkg::REMOTE2_TEMP_READING_ADDR[4:0]];

  // readings are two's complement
  assign t_hi  = ($signed(t_loc) > $signed(t_r1)) ? t_loc : t_r1;
  assign t_max = ($signed(t_hi) > $signed(t_r2)) ? t_hi : t_r2;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      fan1_source_o    <= thermal_fan_monitor_pkg::SRC_REMOTE1;
      fan2_source_o    <= thermal_fan_monitor_pkg::SRC_REMOTE2;
      fan1_ctrl_temp_o <= 8'h00;
      fan2_ctrl_temp_o <= 8'h00;
    end else if (ce_i) begin
      case (map_sel)
        thermal_fan_monitor_pkg::MAP_SPLIT: begin
          fan1_source_o    <= thermal_fan_monitor_pkg::SRC_REMOTE1;
          fan2_source_o    <= thermal_fan_monitor_pkg::SRC_REMOTE2;
          fan1_ctrl_temp_o <= t_r1;
          fan2_ctrl_temp_o <= t_r2;
        end
        thermal_fan_monitor_pkg::MAP_REMOTE1: begin
          fan1_source_o    <= thermal_fan_monitor_pkg::SRC_REMOTE1;
          fan2_source_o    <= thermal_fan_monitor_pkg::SRC_REMOTE1;
          fan1_ctrl_temp_o <= t_r1;
          fan2_ctrl_temp_o <= t_r1;
        end
        thermal_fan_monitor_pkg::MAP_REMOTE2: begin
          fan1_source_o    <= thermal_fan_monitor_pkg::SRC_REMOTE2;
          fan2_source_o    <= thermal_fan_monitor_pkg::SRC_REMOTE2;
          fan1_ctrl_temp_o <= t_r2;
          fan2_ctrl_temp_o <= t_r2;
        end
        default: begin
          fan1_source_o    <= thermal_fan_monitor_pkg::SRC_HOTTEST;
          fan2_source_o    <= thermal_fan_monitor_pkg::SRC_HOTTEST;
          fan1_ctrl_temp_o <= t_max;
          fan2_ctrl_temp_o <= t_max;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // slow fan detection and fault pin

  logic [7:0] tach_new [2];
  logic [7:0] limit    [2];
  logic [2:0] strikes_q [2];
  logic [1:0] fault;

  assign tach_new[0] = fan1_tach_i;
  assign tach_new[1] = fan2_tach_i;
  assign limit[0]    = regs_q[thermal_fan_monitor_pkg::FAN1_SLOW_LIMIT_ADDR[4:0]];
  assign limit[1]    = regs_q[thermal_fan_monitor_pkg::FAN2_SLOW_LIMIT_ADDR[4:0]];

  // default limit FFh can never be exceeded, so no fault until lowered
  for (genvar f = 0; f < 2; f++) begin : g_fan
    always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
        strikes_q[f]  <= 3'h0;
        fan_slow_o[f] <= 1'b0;
      end else if (ce_i && meas_en && tach_valid_i[f]) begin
        fan_slow_o[f] <= tach_new[f] > limit[f];
        if (tach_new[f] > limit[f]) begin
          if (strikes_q[f] != thermal_fan_monitor_pkg::FAULT_STRIKES) begin
            strikes_q[f] <= strikes_q[f] + 3'h1;
          end
        end else begin
          strikes_q[f] <= 3'h0;
        end
      end
    end
    assign fault[f] = strikes_q[f] == thermal_fan_monitor_pkg::FAULT_STRIKES;
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      fan_fault_oe_o <= 1'b0;
    end else if (ce_i) begin
      fan_fault_oe_o <= (|fault) && cfg[thermal_fan_monitor_pkg::CFG_FAULT_EN_BIT];
    end
  end

  assign fan_fault_o = 1'b0;

endmodule : thermal_fan_monitor_regs

// ===== verif/thermal_fan_monitor_properties.sv
`timescale 1ns/10ps
module thermal_fan_monitor_checker (
  input wire logic       core_clk_i,     // clock
  input wire logic       srst_i,         // reset
  input wire logic       ce_i,           // enable
  input wire logic [7:0] reg_addr_i,     // offset
  input wire logic       reg_wr_i,       // write
  input wire logic [7:0] reg_wdata_i,    // wdata
  input wire logic       reg_rd_i,       // read
  input wire logic [7:0] reg_rdata_o,    // rdata
  input wire logic       reg_rvalid_o,   // rvalid
  input wire logic [1:0] tach_valid_i,   // new count
  input wire logic [7:0] fan1_tach_i,    // count 1
  input wire logic [7:0] fan2_tach_i,    // count 2
  input wire logic       alert_req_i,    // alert
  input wire logic [1:0] drive_raw_i,    // raw drive
  input wire logic       monitor_en_o,   // monitor
  input wire logic       rpm_targets_o,  // rpm mode
  input wire logic [1:0] fan1_source_o,  // source 1
  input wire logic [1:0] fan2_source_o,  // source 2
  input wire logic [1:0] drive_o,        // drive
  input wire logic [1:0] fan_slow_o,     // slow
  input wire logic       int_oe_o,       // int pin
  input wire logic       fan_fault_oe_o  // fault pin
);
  // shadow of host-visible state, so no internal probes are needed
  logic [7:0] cfg_q, lim1_q, lim2_q;
  logic [2:0] str1_q, str2_q;
  logic [1:0] drv_want;
  logic       acc1, acc2, hot, fault_en;
  assign acc1 = ce_i && cfg_q[0] && tach_valid_i[0];
  assign acc2 = ce_i && cfg_q[0] && tach_valid_i[1];
  assign hot = str1_q == 3'h5 || str2_q == 3'h5;
  assign fault_en = cfg_q[4];
  assign drv_want = drive_raw_i ^ {2{cfg_q[3]}};
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cfg_q  <= 8'h90;
      lim1_q <= 8'hff;
      lim2_q <= 8'hff;
    end else if (ce_i && reg_wr_i) begin
      cfg_q  <= (reg_addr_i == 8'h00) ? reg_wdata_i : cfg_q;
      lim1_q <= (reg_addr_i == 8'h10) ? reg_wdata_i : lim1_q;
      lim2_q <= (reg_addr_i == 8'h11) ? reg_wdata_i : lim2_q;
    end
  end
  // strikes saturate so a long stall cannot wrap back to zero
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      str1_q <= 3'h0;
      str2_q <= 3'h0;
    end else begin
      if (acc1) str1_q <= (fan1_tach_i > lim1_q) ? (hot && str1_q == 3'h5 ? 3'h5 : str1_q + 3'h1) : 3'h0;
      if (acc2) str2_q <= (fan2_tach_i > lim2_q) ? (str2_q == 3'h5 ? 3'h5 : str2_q + 3'h1) : 3'h0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  monitor_bit_a: assert property (monitor_en_o == cfg_q[0])
    else $error("monitor enable differs from config bit");
  alert_gate_a: assert property (int_oe_o == (alert_req_i && cfg_q[1]))
    else $error("interrupt pin not gated by config");
  // the release edge still loads the reset value, so skip it
  drive_polarity_a: assert property (ce_i && !srst_i |=> drive_o == $past(drv_want))
    else $error("fan drive polarity wrong");
  fault_enable_a: assert property (fan_fault_oe_o |-> fault_en || $past(fault_en))
    else $error("fault pin driven while disabled");
  source_map_a: assert property ($stable(cfg_q) |-> fan1_source_o == (cfg_q[6:5] == 2'h0 ? 2'h1 : cfg_q[6:5])
    && fan2_source_o == (cfg_q[6:5] == 2'h0 ? 2'h2 : cfg_q[6:5]))
    else $error("fan source mapping wrong");
  rpm_mode_a: assert property (rpm_targets_o == (!cfg_q[7] && cfg_q[6:5] == 2'h3))
    else $error("rpm target mode wrong");
  cfg_readback_a: assert property (ce_i && reg_rd_i && reg_addr_i == 8'h00
    |=> reg_rvalid_o && reg_rdata_o == $past(cfg_q)) else $error("config readback wrong");
  slow_flag_a: assert property (acc1 |=> fan_slow_o[0] == ($past(fan1_tach_i) > $past(lim1_q)))
    else $error("slow flag wrong");
  fault_rise_a: assert property ($rose(fan_fault_oe_o) |-> hot || $past(hot))
    else $error("fault pin before five strikes");
  fault_clear_a: assert property (!hot [*3] |-> !fan_fault_oe_o)
    else $error("fault pin held without strikes");
  unmapped_read_a: assert property (ce_i && reg_rd_i && (reg_addr_i inside {8'h12, 8'h13, 8'h17, 8'h1b}
    || reg_addr_i >= 8'h20) |=> reg_rvalid_o && reg_rdata_o == 8'h00) else $error("unmapped read not zero");
endmodule : thermal_fan_monitor_checker

bind thermal_fan_monitor_regs thermal_fan_monitor_checker u_chk (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .tach_valid_i(tach_valid_i), .fan1_tach_i(fan1_tach_i), .fan2_tach_i(fan2_tach_i), .alert_req_i(alert_req_i),
  .drive_raw_i(drive_raw_i), .monitor_en_o(monitor_en_o), .rpm_targets_o(rpm_targets_o),
  .fan1_source_o(fan1_source_o), .fan2_source_o(fan2_source_o), .drive_o(drive_o), .fan_slow_o(fan_slow_o),
  .int_oe_o(int_oe_o), .fan_fault_oe_o(fan_fault_oe_o));

// ===== verif/host_access_model.sv
`timescale 1ns/10ps
module host_access_model (
  input  wire logic       core_clk_i,   // clock
  output logic      [7:0] reg_addr_o,   // offset
  output logic            reg_wr_o,     // write strobe
  output logic      [7:0] reg_wdata_o,  // write data
  output logic            reg_rd_o,     // read strobe
  input  wire logic [7:0] reg_rdata_i,  // read data
  input  wire logic       reg_rvalid_i  // read valid
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o = 1'b0;
  end
  // released lines show inverted values so a stale address cannot pass
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk_i);
    reg_addr_o <= addr;
    reg_wdata_o <= data;
    reg_wr_o <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~addr;
    reg_wdata_o <= ~data;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    int n;
    @(posedge core_clk_i);
    reg_addr_o <= addr;
    reg_rd_o <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~addr;
    ok = 1'b0;
    data = 8'h00;
    for (n = 0; n < 4 && !ok; n++) begin
      #1;
      if (reg_rvalid_i === 1'b1) begin
        data = reg_rdata_i;
        ok = 1'b1;
      end else @(posedge core_clk_i);
    end
  endtask : read_reg
endmodule : host_access_model

// ===== verif/thermal_fan_monitor_regs_test.sv
`timescale 1ns/10ps
module thermal_fan_monitor_regs_test;
  logic       core_clk_i, srst_i, ce_i, reg_wr_i, reg_rd_i, reg_rvalid_o, temp_valid_i, alert_req_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, fan1_tach_i, fan2_tach_i, ext_bits_i;
  logic [7:0] local_temp_i, remote1_temp_i, remote2_temp_i, fan1_ctrl_temp_o, fan2_ctrl_temp_o;
  logic [1:0] tach_valid_i, drive_raw_i, fan1_source_o, fan2_source_o, drive_o, fan_slow_o;
  logic       monitor_en_o, speed_input_select_o, automatic_control_select_o, rpm_targets_o;
  logic       int_o, int_oe_o, fan_fault_o, fan_fault_oe_o;
  int         n_fail, cmp_count;
  logic [7:0] cfg;
  logic [7:0] rw_addr[14] = '{8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h14, 8'h15, 8'h16, 8'h18, 8'h19, 8'h1a,
                              8'h1c, 8'h1d, 8'h1e};
  logic [7:0] rw_def[14] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h3c, 8'h00, 8'h46, 8'h50, 8'h00, 8'h64,
                             8'h50, 8'h00, 8'h64};
  logic [7:0] ro_addr[8] = '{8'h06, 8'h0a, 8'h0b, 8'h0c, 8'h12, 8'h13, 8'h17, 8'h1b};

  thermal_fan_monitor_regs u_dut (.*);
  host_access_model u_host (.core_clk_i(core_clk_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
    .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    u_host.read_reg(addr, d, ok);
    if (!ok) begin
      n_fail++;
      $display("Error read answer expected 1 seen 0");
      finish_test();
    end else begin
      check($sformatf("reg %h", addr), d, exp);
    end
  endtask : rchk
  task automatic tach(input logic [1:0] v, input logic [7:0] c1, input logic [7:0] c2);
    @(posedge core_clk_i);
    tach_valid_i <= v;
    fan1_tach_i <= c1;
    fan2_tach_i <= c2;
    @(posedge core_clk_i);
    tach_valid_i <= 2'h0;
  endtask : tach
  task automatic wait_pins();
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask : wait_pins
  // expected pins worked out from the config byte, alert_req_i and drive_raw_i
  task automatic pins(input logic [7:0] c);
    logic [1:0] m;
    m = c[6:5];
    check("cfg pins", {1'b0, monitor_en_o, speed_input_select_o, automatic_control_select_o, rpm_targets_o,
      int_oe_o, drive_o}, {1'b0, c[0], c[2], c[7], !c[7] && m == 2'h3, c[1] & alert_req_i, drive_raw_i ^ {2{c[3]}}});
    check("sources", {4'h0, fan1_source_o, fan2_source_o}, {4'h0, m == 2'h0 ? 2'h1 : m, m == 2'h0 ? 2'h2 : m});
  endtask : pins
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    srst_i = 1'b1;
    ce_i = 1'b1;
    {tach_valid_i, temp_valid_i, fan1_tach_i, fan2_tach_i, ext_bits_i} = '0;
    {local_temp_i, remote1_temp_i, remote2_temp_i} = '0;
    alert_req_i = 1'b1;
    drive_raw_i = 2'h1;
    repeat (4) @(posedge core_clk_i);
    srst_i <= 1'b0;
    rchk(8'h00, 8'h90);
    pins(8'h90);
    foreach (rw_addr[i]) rchk(rw_addr[i], rw_def[i]);
    $display("test reset values done");
    foreach (rw_addr[i]) u_host.write_reg(rw_addr[i], rw_addr[i] ^ 8'h5a);
    foreach (rw_addr[i]) rchk(rw_addr[i], rw_addr[i] ^ 8'h5a);
    foreach (ro_addr[i]) u_host.write_reg(ro_addr[i], 8'h77);
    foreach (ro_addr[i]) rchk(ro_addr[i], 8'h00);
    $display("test access kinds done");
    for (int i = 0; i < 16; i++) begin
      cfg = {i[3], i[2:1], 1'b1, i[0], i[1], i[2], 1'b0};
      drive_raw_i <= i[1:0];
      u_host.write_reg(8'h00, cfg);
      wait_pins();
      pins(cfg);
      rchk(8'h00, cfg);
    end
    $display("test config modes done");
    u_host.write_reg(8'h10, 8'hff);
    u_host.write_reg(8'h00, 8'h10);
    tach(2'h3, 8'h21, 8'h22);
    rchk(8'h08, 8'h00);
    u_host.write_reg(8'h00, 8'h91);
    @(posedge core_clk_i);
    {local_temp_i, remote1_temp_i, remote2_temp_i, ext_bits_i} <= 32'h1ee740c9;
    temp_valid_i <= 1'b1;
    @(posedge core_clk_i);
    temp_valid_i <= 1'b0;
    rchk(8'h0a, 8'h1e);
    rchk(8'h0b, 8'he7);
    rchk(8'h0c, 8'h40);
    rchk(8'h06, 8'hc9);
    check("fan1 temp", fan1_ctrl_temp_o, 8'he7);
    check("fan2 temp", fan2_ctrl_temp_o, 8'h40);
    // e7h is negative, an unsigned maximum would wrongly pick it
    u_host.write_reg(8'h00, 8'hf1);
    wait_pins();
    check("fan1 hottest", fan1_ctrl_temp_o, 8'h40);
    check("fan2 hottest", fan2_ctrl_temp_o, 8'h40);
    tach(2'h3, 8'h21, 8'h22);
    rchk(8'h08, 8'h21);
    rchk(8'h09, 8'h22);
    u_host.write_reg(8'h08, 8'h33);
    rchk(8'h08, 8'h33);
    $display("test measurements done");
    u_host.write_reg(8'h10, 8'hfe);
    repeat (4) tach(2'h1, 8'hff, 8'h10);
    wait_pins();
    check("fault pin", {7'h0, fan_fault_oe_o}, 8'h00);
    check("slow", {6'h0, fan_slow_o}, 8'h01);
    tach(2'h1, 8'hff, 8'h10);
    wait_pins();
    check("fault pin", {7'h0, fan_fault_oe_o}, 8'h01);
    check("pin levels", {6'h0, int_o, fan_fault_o}, 8'h00);
    tach(2'h1, 8'hfe, 8'h10);
    wait_pins();
    check("fault pin", {7'h0, fan_fault_oe_o}, 8'h00);
    u_host.write_reg(8'h00, 8'h81);
    repeat (5) tach(2'h1, 8'hff, 8'h10);
    wait_pins();
    check("fault pin", {7'h0, fan_fault_oe_o}, 8'h00);
    u_host.write_reg(8'h00, 8'h91);
    wait_pins();
    check("fault pin", {7'h0, fan_fault_oe_o}, 8'h01);
    $display("test fan fault done");
    finish_test();
  end
endmodule : thermal_fan_monitor_regs_test
